/* hdl/i2cst_pair_buf.sv */
/*
  Two-entry buffer with valid/ready on both sides, used in the transmit byte path.
  Assumes a single clock and a synchronous, active-high reset from the instantiating block.
*/
module i2cst_pair_buf #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             push;
  logic             pop;

  // handshakes and next occupancy
  always_comb begin
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  // occupancy and flags, all registered so ports come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready  <= (count_next != 2'h2); // full stalls the writer, no word lost
      out_valid <= (count_next != 2'h0);
    end
  end

  // storage: head always holds the oldest word
  always_ff @(posedge clk) begin
    if (rst) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else if (pop) begin
      head_reg <= (count_reg == 2'h2) ? tail_reg : in_data;
      if (push && count_reg == 2'h2) begin
        tail_reg <= in_data;
      end
    end else if (push) begin
      if (count_reg == 2'h0) begin
        head_reg <= in_data;
      end else begin
        tail_reg <= in_data;
      end
    end
  end

  assign out_data = head_reg;

endmodule : i2cst_pair_buf

/* hdl/i2cst_slave.sv */
/*
  Constants package and top module of the two-wire serial slave: 8-bit transmit,
  address/data hold, 10-bit address handshake, clock stretching and collision detect.
  Assumes open-drain pads outside (oe high pulls the line low) and a bus master
  whose SCL is slow against mclk (100 MHz); both lines are synchronised here.
*/
// Overview of operation
// RL1 - read address match: flag read, buffer, acknowledge
// RL2 - after read address ack, drop release, hold clock
// RL3 - software loads byte, then sets clock release
// RL4 - transmit bits change on clock falling edges
// RL5 - master acknowledge sampled on ninth rising edge
// RL6 - master nack: no hold, event, go idle
// RL7 - master ack: stretch until next byte released
// RL8 - event flag on ninth falling edge, software clears
// RL9 - enabled collision while sending: flag, go idle
// RL10 - address hold: stretch and event after eighth fall
// RL11 - software picks ack value, then releases clock
// RL12 - load transmit data only after address ack
// RL13 - master nacks last byte before stop
// RL14 - 10-bit address bytes set update-needed, ack, event
// RL15 - update-needed stretches; address write frees it
// RL16 - low byte mismatch: event, update-needed, no buffer
// RL17 - software rewrites address after each ack sequence
// RL18 - stretch enable: hold after every received byte
// RL19 - hold clock only once seen low; release frees
// RL20 - stretch enable holds after every acknowledge sequence
// RL21 - read request always drops release, buffer regardless
// RL22 - data hold: stretch after eighth fall of data
// RL23 - 10-bit high byte: 11110, address bits 2:1
// RL24 - ack phase flag after eighth fall, holds only; code sets it on any accepted byte while either hold enable is on
// RL25 - lines only pulled low; sda freed for ack
package i2cst_pkg;

  localparam int        BYTE_BITS       = 8;
  localparam logic [3:0] BIT_CNT_FULL   = 4'h8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e; // 11110
  localparam logic [7:0] ADDR_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;

  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_ack_out,
    st_tx_load,
    st_tx,
    st_ack_in
  } i2cst_state_t;

  typedef enum logic [1:0] {
    kind_addr,
    kind_addr_lo,
    kind_data
  } i2cst_kind_t;

endpackage : i2cst_pkg

module i2cst_slave (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // bus pins, open drain
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_out,
  output logic            sda_oe,
  // transmit bytes from software
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // received bytes to software
  output logic      [7:0] serial_buffer,
  output logic            buffer_full,
  input  wire logic       rx_read,
  // address and control
  input  wire logic       address_write,
  input  wire logic [7:0] address_wdata,
  output logic      [7:0] slave_address_reg,
  input  wire logic       clock_release_set,
  input  wire logic       ten_bit_mode,
  input  wire logic       stretch_enable,
  input  wire logic       address_hold_enable,
  input  wire logic       data_hold_enable,
  input  wire logic       slave_collision_detect_enable,
  input  wire logic       ack_value_select,
  input  wire logic       event_clear,
  input  wire logic       collision_clear,
  // status
  output logic            clock_release,
  output logic            port_event_flag,
  output logic            bus_collision_flag,
  output logic            received_ack_flag,
  output logic            ack_phase_flag,
  output logic            read_not_write,
  output logic            data_not_address,
  output logic            address_update_needed
);

  i2cst_pkg::i2cst_state_t state_reg;
  i2cst_pkg::i2cst_kind_t  kind_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       scl_meta, scl_s, scl_d;
  logic       sda_meta, sda_s, sda_d;
  logic       ack_ok_reg;
  logic       hold_active_reg;
  logic       read_addr_reg;
  logic       ten_matched_reg;
  logic [7:0] buf_data;
  logic       buf_valid;
  logic       buf_pop;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       rx_done, addr_hit, lo_hit, accept, hold8;
  logic       ack9_fall, ack_given, ack9_event, ackin_fall, collide;
  logic       hw_release_clear;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= scl_pin;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= sda_pin;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
    end
  end

  // bus events and byte decisions
  always_comb begin
    scl_rise   = scl_s && !scl_d;
    scl_fall   = !scl_s && scl_d;
    start_det  = scl_s && scl_d && sda_d && !sda_s;
    stop_det   = scl_s && scl_d && !sda_d && sda_s;
    rx_done    = (state_reg == i2cst_pkg::st_rx) && scl_fall && (bit_cnt_reg == i2cst_pkg::BIT_CNT_FULL);
    // 10-bit read only valid after a full high+low write match
    addr_hit   = (kind_reg == i2cst_pkg::kind_addr) && (ten_bit_mode ?
                 (shift_reg[7:3] == i2cst_pkg::TEN_BIT_PREFIX && shift_reg[2:1] == slave_address_reg[2:1]
                  && (!shift_reg[0] || ten_matched_reg)) :                                  // [RL23]
                 (shift_reg[7:1] == slave_address_reg[7:1]));
    lo_hit     = (kind_reg == i2cst_pkg::kind_addr_lo) && (shift_reg == slave_address_reg);
    accept     = rx_done && (addr_hit || lo_hit || (kind_reg == i2cst_pkg::kind_data && !buffer_full));
    hold8      = rx_done && ((addr_hit && address_hold_enable)                              // [RL10]
                 || (kind_reg == i2cst_pkg::kind_data && !buffer_full && data_hold_enable)); // [RL22]
    ack9_fall  = (state_reg == i2cst_pkg::st_ack_out) && scl_fall;
    ack_given  = ack_ok_reg && (!hold_active_reg || !ack_value_select);                     // [RL11]
    ack9_event = ack9_fall && (ack_given || kind_reg == i2cst_pkg::kind_addr_lo);          // [RL8] [RL16]
    ackin_fall = (state_reg == i2cst_pkg::st_ack_in) && scl_fall;
    collide    = (state_reg == i2cst_pkg::st_tx) && scl_rise && !sda_oe && !sda_s
                 && slave_collision_detect_enable;                                          // [RL9]
    // read address always drops release; high 10-bit write and low byte rely on update-needed
    hw_release_clear = hold8
                 || (ack9_fall && ack_given && (read_addr_reg                               // [RL2] [RL21]
                     || (stretch_enable && kind_reg == i2cst_pkg::kind_data)                // [RL18]
                     || (stretch_enable && kind_reg == i2cst_pkg::kind_addr && !ten_bit_mode)))  // [RL20]
                 || (ackin_fall && !received_ack_flag);                                     // [RL7]
    buf_pop    = (state_reg == i2cst_pkg::st_tx_load) && buf_valid;
  end

  // transmit bytes queue here so a busy shifter never drops a software write
  i2cst_pair_buf #(
    .WIDTH (8)
  ) u_tx_buf (
    .clk       (mclk),
    .rst       (sys_rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // byte sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg       <= i2cst_pkg::st_idle;
      kind_reg        <= i2cst_pkg::kind_addr;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= i2cst_pkg::DATA_RESET;
      tx_shift_reg    <= i2cst_pkg::DATA_RESET;
      ack_ok_reg      <= 1'b0;
      hold_active_reg <= 1'b0;
      read_addr_reg   <= 1'b0;
      ten_matched_reg <= 1'b0;
    end else if (start_det) begin
      // start or restart: the next byte is always an address
      state_reg   <= i2cst_pkg::st_rx;
      kind_reg    <= i2cst_pkg::kind_addr;
      bit_cnt_reg <= 4'h0;
    end else if (stop_det) begin
      state_reg       <= i2cst_pkg::st_idle;
      ten_matched_reg <= 1'b0;
    end else begin
      case (state_reg)
        i2cst_pkg::st_rx: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            if (accept || kind_reg == i2cst_pkg::kind_addr_lo) begin
              state_reg       <= i2cst_pkg::st_ack_out;
              ack_ok_reg      <= accept;       // only a low-byte mismatch answers nack here
              hold_active_reg <= hold8;
              read_addr_reg   <= addr_hit && shift_reg[0];
            end else begin
              state_reg <= i2cst_pkg::st_idle; // not us, or data overflow: no trace left
            end
            bit_cnt_reg <= 4'h0;
          end
        end
        i2cst_pkg::st_ack_out: begin
          if (ack9_fall) begin
            if (!ack_given) begin
              state_reg <= i2cst_pkg::st_idle;
            end else if (read_addr_reg) begin
              state_reg <= i2cst_pkg::st_tx_load;            // [RL1]
            end else begin
              state_reg <= i2cst_pkg::st_rx;
              if (kind_reg == i2cst_pkg::kind_addr && ten_bit_mode && !ten_matched_reg) begin
                kind_reg <= i2cst_pkg::kind_addr_lo;         // [RL14]
              end else begin
                kind_reg <= i2cst_pkg::kind_data;
              end
              if (kind_reg == i2cst_pkg::kind_addr_lo) begin
                ten_matched_reg <= 1'b1;
              end
            end
          end
        end
        i2cst_pkg::st_tx_load: begin
          // clock is held low here, so the first bit settles before release
          if (buf_valid) begin
            tx_shift_reg <= buf_data;                        // [RL3]
            bit_cnt_reg  <= 4'h0;
            state_reg    <= i2cst_pkg::st_tx;
          end
        end
        i2cst_pkg::st_tx: begin
          if (collide) begin
            state_reg <= i2cst_pkg::st_idle;                 // [RL9]
          end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == i2cst_pkg::BIT_CNT_FULL) begin
              state_reg <= i2cst_pkg::st_ack_in;
            end else begin
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};     // [RL4]
            end
          end
        end
        i2cst_pkg::st_ack_in: begin
          if (ackin_fall) begin
            state_reg <= received_ack_flag ? i2cst_pkg::st_idle : i2cst_pkg::st_tx_load; // [RL6] [RL7]
          end
        end
        default: begin
          state_reg <= i2cst_pkg::st_idle;
        end
      endcase
    end
  end

  // pin drive: only ever pull low; sda freed while the master acknowledges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= 1'b0;                                                    // [RL25]
      sda_out <= 1'b0;                                                    // [RL25]
      // never grab a high clock: that would cut the master's high time short
      scl_oe  <= (state_reg != i2cst_pkg::st_idle || address_update_needed)
                 && (!clock_release || address_update_needed) && !scl_s; // [RL19] [RL15]
      case (state_reg)
        i2cst_pkg::st_ack_out: sda_oe <= ack_given && !ack9_fall;
        i2cst_pkg::st_tx:      sda_oe <= !tx_shift_reg[7] && !collide && !(scl_fall
                                         && bit_cnt_reg == i2cst_pkg::BIT_CNT_FULL);
        default:               sda_oe <= 1'b0;                           // [RL25]
      endcase
    end
  end

  // clock release: hardware clear wins over a same-cycle software set
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clock_release <= 1'b1;
    end else if (hw_release_clear) begin
      clock_release <= 1'b0;                                              // [RL2] [RL10] [RL22]
    end else if (clock_release_set) begin
      clock_release <= 1'b1;                                              // [RL19]
    end
  end

  // event and collision flags: set wins over clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_event_flag    <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else begin
      if (hold8 || ack9_event || ackin_fall) begin
        port_event_flag <= 1'b1;                                          // [RL8] [RL6] [RL10]
      end else if (event_clear) begin
        port_event_flag <= 1'b0;
      end
      if (collide) begin
        bus_collision_flag <= 1'b1;                                       // [RL9]
      end else if (collision_clear) begin
        bus_collision_flag <= 1'b0;
      end
    end
  end

  // address register and update-needed handshake
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slave_address_reg     <= i2cst_pkg::ADDR_RESET;
      address_update_needed <= 1'b0;
    end else begin
      if (address_write) begin
        slave_address_reg <= address_wdata;
      end
      if (ack9_fall && (kind_reg == i2cst_pkg::kind_addr_lo
          || (ack_given && kind_reg == i2cst_pkg::kind_addr && ten_bit_mode && !read_addr_reg))) begin
        address_update_needed <= 1'b1;                                    // [RL14] [RL16]
      end else if (address_write) begin
        address_update_needed <= 1'b0;                                    // [RL15]
      end
    end
  end

  // receive buffer and byte status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_buffer    <= i2cst_pkg::DATA_RESET;
      buffer_full      <= 1'b0;
      read_not_write   <= 1'b0;
      data_not_address <= 1'b0;
    end else begin
      if (accept) begin
        serial_buffer    <= shift_reg;                                    // [RL1]
        data_not_address <= (kind_reg == i2cst_pkg::kind_data);
        if (addr_hit) begin
          read_not_write <= shift_reg[0];                                 // [RL1]
        end
      end
      if (accept) begin
        buffer_full <= 1'b1;                                              // [RL16]
      end else if (rx_read) begin
        buffer_full <= 1'b0;
      end
    end
  end

  // acknowledge status and ack-phase marker
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      received_ack_flag <= 1'b0;
      ack_phase_flag    <= 1'b0;
    end else begin
      if (state_reg == i2cst_pkg::st_ack_in && scl_rise) begin
        received_ack_flag <= sda_s;                                       // [RL5]
      end
      if (accept && (address_hold_enable || data_hold_enable)) begin
        ack_phase_flag <= 1'b1;                                           // [RL24]
      end else if (ack9_fall || start_det || stop_det) begin
        ack_phase_flag <= 1'b0;
      end
    end
  end

  // checks
  scl_grab_low_a: assert property (@(posedge mclk) disable iff (sys_rst)   // [RL19]
    $rose(scl_oe) |-> !$past(scl_s)) else $error("scl pulled while seen high");
  release_frees_a: assert property (@(posedge mclk) disable iff (sys_rst)  // [RL19]
    clock_release && !address_update_needed ##1 clock_release && !address_update_needed |-> !scl_oe)
    else $error("scl held while released");
  read_ack_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)  // [RL2]
    ack9_fall && ack_given && read_addr_reg |=> !clock_release && state_reg == i2cst_pkg::st_tx_load)
    else $error("read address ack did not stretch");
  ack_sample_a: assert property (@(posedge mclk) disable iff (sys_rst)     // [RL5]
    state_reg == i2cst_pkg::st_ack_in && scl_rise && !start_det && !stop_det
    |=> received_ack_flag == $past(sda_s)) else $error("master ack not captured");
  nack_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)      // [RL6]
    ackin_fall && received_ack_flag && !start_det && !stop_det
    |=> state_reg == i2cst_pkg::st_idle && port_event_flag && clock_release == $past(clock_release))
    else $error("nack did not end transfer");
  ninth_event_a: assert property (@(posedge mclk) disable iff (sys_rst)    // [RL8]
    ackin_fall |=> port_event_flag) else $error("no event on ninth fall");
  collision_a: assert property (@(posedge mclk) disable iff (sys_rst)      // [RL9]
    collide && !start_det && !stop_det |=> bus_collision_flag && state_reg == i2cst_pkg::st_idle ##1 !sda_oe)
    else $error("collision not handled");
  addr_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)      // [RL10]
    rx_done && addr_hit && address_hold_enable |=> !clock_release && port_event_flag && ack_phase_flag)
    else $error("address hold missing");
  update_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)   // [RL15]
    address_write && !ack9_fall |=> !address_update_needed) else $error("address write kept update flag");
  tx_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)      // [RL4]
    state_reg == i2cst_pkg::st_tx && $past(state_reg) == i2cst_pkg::st_tx && scl_s && $past(scl_s)
    && $past(scl_s, 2) |-> $stable(sda_oe)) else $error("sda moved while scl high");
  tx_byte_c:   cover property (@(posedge mclk) disable iff (sys_rst) ackin_fall && !received_ack_flag);
  ten_bit_c:   cover property (@(posedge mclk) disable iff (sys_rst) ack9_fall && kind_reg == i2cst_pkg::kind_addr_lo);
  collision_c: cover property (@(posedge mclk) disable iff (sys_rst) collide);

endmodule : i2cst_slave

/* test/i2cst_master_model.sv */
/*
  Behavioural two-wire bus master: start, stop and byte transfers with stretch wait.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
module i2cst_master_model (
  // resolved lines
  input  wire logic scl_line,
  input  wire logic sda_line,
  // pull-downs, high pulls the line low
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // lines released at time zero, clock stands high outside frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // sda falls while scl high
  task automatic start;
    sda_low = 1'b1;
    #62;
    scl_low = 1'b1;
    #31;
  endtask : start

  // sda rises while scl high
  task automatic stop;
    sda_low = 1'b1;
    #31;
    scl_low = 1'b0;
    #62;
    sda_low = 1'b0;
    #62;
  endtask : stop

  // one bit; high phase waits while the slave stretches, bounded so a stuck line ends
  task automatic clk_bit(input logic b, output logic r);
    int n;
    sda_low = ~b;
    #31;
    scl_low = 1'b0;
    n = 0;
    while (scl_line !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    #31;
    r = sda_line;
    #31;
    scl_low = 1'b1;
    #32;
  endtask : clk_bit

  // eight bits msb first, then the ack bit; a 1 is sent by releasing sda
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(ack, ack_seen);
  endtask : xfer
endmodule : i2cst_master_model

/* test/i2cst_slave_tb.sv */
/*
  Self-checking bench for the two-wire slave: reads with and without address hold,
  collision, 10-bit address handshake.
  Assumes the behavioural master model and pull-ups on both lines.
*/
module i2cst_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // inputs, driven at the falling edge
  logic       mclk = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0, rx_read = 1'b0, address_write = 1'b0;
  logic       clock_release_set = 1'b0, ten_bit_mode = 1'b0, stretch_enable = 1'b0, address_hold_enable = 1'b0;
  logic       data_hold_enable = 1'b0, slave_collision_detect_enable = 1'b0, ack_value_select = 1'b0;
  logic       event_clear = 1'b0, collision_clear = 1'b0;
  logic [7:0] tx_data = 8'h00, address_wdata = 8'h00;
  // outputs and resolved lines
  logic       scl_out, scl_oe, sda_out, sda_oe, tx_ready, buffer_full, clock_release, port_event_flag;
  logic       bus_collision_flag, received_ack_flag, ack_phase_flag, read_not_write, data_not_address;
  logic       address_update_needed, m_scl_low, m_sda_low;
  logic [7:0] serial_buffer, slave_address_reg;
  wire        scl_pin = (scl_oe ? scl_out : 1'b1) & ~m_scl_low;
  wire        sda_pin = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;
  int         errors = 0, checked = 0;
  localparam logic [7:0] TX_VALS [3] = '{8'h3c, 8'hc3, 8'h81};

  i2cst_slave uut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin(sda_pin), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .serial_buffer(serial_buffer), .buffer_full(buffer_full), .rx_read(rx_read), .address_write(address_write),
    .address_wdata(address_wdata), .slave_address_reg(slave_address_reg), .clock_release_set(clock_release_set),
    .ten_bit_mode(ten_bit_mode), .stretch_enable(stretch_enable), .address_hold_enable(address_hold_enable),
    .data_hold_enable(data_hold_enable), .slave_collision_detect_enable(slave_collision_detect_enable),
    .ack_value_select(ack_value_select), .event_clear(event_clear), .collision_clear(collision_clear),
    .clock_release(clock_release), .port_event_flag(port_event_flag), .bus_collision_flag(bus_collision_flag),
    .received_ack_flag(received_ack_flag), .ack_phase_flag(ack_phase_flag), .read_not_write(read_not_write),
    .data_not_address(data_not_address), .address_update_needed(address_update_needed)
  );

  i2cst_master_model m (.scl_line(scl_pin), .sda_line(sda_pin), .scl_low(m_scl_low), .sda_low(m_sda_low));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // one-cycle pulse, raised and dropped at falling edges
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse

  // bounded wait: sel 0 for the clock hold, 1 for the event flag
  task automatic wait_for(input logic sel);
    for (int i = 0; i < 400 && (sel ? port_event_flag : scl_oe) !== 1'b1; i++) begin
      @(negedge mclk);
    end
  endtask : wait_for

  task automatic read_seq(input logic hold);
    logic [7:0] q;
    logic       a;
    int         n;
    address_hold_enable = hold;
    m.start();
    fork
      m.xfer(8'ha5, 1'b1, q, a);
      if (hold) begin
        wait_for(1'b0);
        chk("hold event", port_event_flag, 8'h01);
        chk("ack phase", ack_phase_flag, 8'h01);
        chk("hold release", clock_release, 8'h00);
        pulse(event_clear);
        ack_value_select = 1'b0;
        pulse(clock_release_set);
      end
    join
    chk("address ack", a, 8'h00);
    wait_for(1'b0);
    chk("read flag", read_not_write, 8'h01);
    chk("address byte", serial_buffer, 8'ha5);
    chk("read stretch", clock_release, 8'h00);
    chk("ninth fall event", port_event_flag, 8'h01);
    pulse(rx_read);
    pulse(event_clear);
    // fill the transmit buffer until it refuses; loaded only after the ack
    n = 0;
    while (tx_ready === 1'b1 && n < 3) begin
      tx_data = TX_VALS[n];
      pulse(tx_valid);
      n++;
    end
    chk("buffer refuses", tx_ready, 8'h00);
    for (int k = 0; k < n; k++) begin
      pulse(clock_release_set);
      m.xfer(8'hff, k == n - 1, q, a);
      chk("tx byte", q, TX_VALS[k]);
      chk("master ack", received_ack_flag, {7'h00, k == n - 1});
      wait_for(1'b1);
      chk("byte event", port_event_flag, 8'h01);
      if (k < n - 1) begin
        wait_for(1'b0);
        chk("ack stretch", clock_release, 8'h00);
      end else begin
        chk("nack no hold", scl_oe, 8'h00);
      end
      pulse(event_clear);
    end
    m.stop();
    chk("buffer drained", tx_ready, 8'h01);
  endtask : read_seq

  task automatic collide;
    logic [7:0] q;
    logic       a;
    slave_collision_detect_enable = 1'b1;
    address_hold_enable = 1'b0;
    m.start();
    m.xfer(8'ha5, 1'b1, q, a);
    wait_for(1'b0);
    pulse(rx_read);
    pulse(event_clear);
    tx_data = 8'hf0;
    pulse(tx_valid);
    pulse(clock_release_set);
    // master holds sda low against the slave's leading 1
    m.xfer(8'h00, 1'b1, q, a);
    chk("collision flag", bus_collision_flag, 8'h01);
    chk("idle after collision", scl_oe, 8'h00);
    m.stop();
    pulse(collision_clear);
    pulse(event_clear);
    slave_collision_detect_enable = 1'b0;
  endtask : collide

  task automatic ten_bit;
    logic [7:0] q;
    logic       a;
    ten_bit_mode = 1'b1;
    address_wdata = 8'h06;
    pulse(address_write);
    m.start();
    m.xfer(8'hf6, 1'b1, q, a);
    chk("high byte ack", a, 8'h00);
    wait_for(1'b0);
    chk("update needed", address_update_needed, 8'h01);
    chk("high byte event", port_event_flag, 8'h01);
    chk("release kept", clock_release, 8'h01);
    pulse(rx_read);
    pulse(event_clear);
    address_wdata = 8'h5a;
    pulse(address_write);
    @(negedge mclk);
    chk("update cleared", address_update_needed, 8'h00);
    chk("clock freed", scl_oe, 8'h00);
    chk("low address", slave_address_reg, 8'h5a);
    m.xfer(8'h33, 1'b1, q, a); // low byte that does not match
    wait_for(1'b0);
    chk("mismatch event", port_event_flag, 8'h01);
    chk("mismatch update", address_update_needed, 8'h01);
    chk("mismatch no buffer", buffer_full, 8'h00);
    chk("mismatch release", clock_release, 8'h01);
    address_wdata = 8'h06;
    pulse(address_write);
    @(negedge mclk);
    chk("freed again", scl_oe, 8'h00);
    m.stop();
    pulse(event_clear);
    ten_bit_mode = 1'b0;
    address_wdata = 8'ha4;
    pulse(address_write);
  endtask : ten_bit

  // watchdog, far beyond the dozen bytes of traffic
  initial begin
    #500000;
    errors++;
    close_out();
  end

  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("release at reset", clock_release, 8'h01);
    address_wdata = 8'ha4;
    pulse(address_write);
    read_seq(1'b0);
    read_seq(1'b1);
    collide();
    ten_bit();
    close_out();
  end
endmodule : i2cst_slave_tb
